// [design/rf_tx_control_word_bank.sv]
// control word bank of a multiband transmitter: serial load, mode select, bit-rate chain
// assumes mclk is the 10 MHz reference; serial, strobe and mode pins are asynchronous
//
// Contract
// - reset loads every word with defaults
// - mode pin picks word zero or one
// - counter ratios in bits 21:17 and 16:8
// - bits 7:6 give attenuation code
// - word zero bits 3:2 give pump current
// - word zero bits 1:0 give band divider
// - word one bit 4 selects modulation
// - word one bit 3 gates amplifier
// - word one bits 2:0 set brownout
// - reference ratio bits 21:14, host 2..255
// - first rate divider 1,5,6,8
// - second rate divider two to code
// - third rate divider 16 or 15
// - capture low passes data straight through
// - capture high samples data on rate clock
// - bits 12:11 route the multipurpose pin
// - trim bit 20 closes crystal switch under on-off keying
// - trim bits 18:16 pick load capacitance
// - trim bit 15 picks detector reset source
// - standby low powers down, programming stays
// - 24 bits shifted, committed on strobe rise
// - address from bits 23,22,1,0
`timescale 1ns/1ps
`include "rf_tx_defines.svh"
`default_nettype none
module rf_tx_control_word_bank
  import rf_tx_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       serial_clock,
  input  wire logic       serial_data,
  input  wire logic       latch_strobe,
  input  wire logic       mode_select,
  input  wire logic       standby_pin,
  input  wire logic       tx_data,
  input  wire logic       lock_detect,
  input  wire logic       brownout_detect,
  output logic            powered_up,
  output logic [4:0]      counter_a_ratio,
  output logic [8:0]      counter_b_ratio,
  output logic [1:0]      amp_attenuation,
  output logic            tx_path_enable,
  output logic [1:0]      pump_current_select,
  output logic [1:0]      band_divider_select,
  output logic            fsk_select,
  output logic            amp_enable,
  output logic [1:0]      brownout_threshold,
  output logic            brownout_enable,
  output logic [7:0]      reference_ratio,
  output logic            multipurpose_output_pin,
  output logic            modulation_data,
  output logic            crystal_switch_closed,
  output logic [2:0]      crystal_load_trim,
  output logic            phase_detector_reset_source
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       sclk_prev;
  logic       strobe_prev;

  // two flops for every async pin; nothing but the second stage reads the first
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {serial_clock, serial_data, latch_strobe, mode_select, standby_pin};
      sync_b <= sync_a;
    end
  end

  // edge history reads only the second stage; both pins idle low, so no false edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_prev   <= 1'b0;
      strobe_prev <= 1'b0;
    end else begin
      sclk_prev   <= sync_b[4];
      strobe_prev <= sync_b[2];
    end
  end

  logic sclk_rise;
  logic strobe_rise;
  logic mode_s;
  assign sclk_rise   = sync_b[4] & ~sclk_prev;
  assign strobe_rise = sync_b[2] & ~strobe_prev;
  assign mode_s      = sync_b[1];

  // ****************************************
  // serial shift register
  // ****************************************
  logic [23:0] shift_reg;

  // msb first; a bit enters on each serial clock rise
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_reg <= 24'h000000;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[22:0], sync_b[3]};
    end
  end

  // ****************************************
  // address decode and word storage
  // ****************************************
  logic [3:0] addr;
  word_sel_e  sel;
  logic       sel_valid;
  assign addr = {shift_reg[23:22], shift_reg[1:0]};

  // don't-care address bits are masked; trim word answers to 11x0
  always_comb begin
    sel       = SEL_MODE_ZERO;
    sel_valid = 1'b1;
    case (addr[3:2])
      2'h0: sel = SEL_MODE_ZERO;
      2'h1: sel = SEL_MODE_ONE;
      2'h2: begin
        if (addr == `REF_WORD_ADDR) begin
          sel = SEL_REF;
        end else if (addr == `RATE_WORD_ADDR) begin
          sel = SEL_RATE;
        end else begin
          sel_valid = 1'b0;
        end
      end
      2'h3: begin
        sel       = SEL_TRIM;
        sel_valid = ~addr[0];
      end
      default: sel_valid = 1'b0;
    endcase
  end

  word_t mode_zero_setting_word;
  word_t mode_one_setting_word;
  word_t reference_divider_word;
  word_t bit_rate_and_pin_word;
  word_t crystal_trim_word;

  // mode zero word: default at reset, changes only on its own commit
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_zero_setting_word <= `MODE_ZERO_RESET;
    end else if (strobe_rise && sel_valid && sel == SEL_MODE_ZERO) begin
      mode_zero_setting_word <= shift_reg[21:0];
    end
  end

  // mode one word
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_one_setting_word <= `MODE_ONE_RESET;
    end else if (strobe_rise && sel_valid && sel == SEL_MODE_ONE) begin
      mode_one_setting_word <= shift_reg[21:0];
    end
  end

  // reference word; the host keeps the ratio legal, no clamp here
  always_ff @(posedge mclk) begin
    if (rst) begin
      reference_divider_word <= `REF_WORD_RESET;
    end else if (strobe_rise && sel_valid && sel == SEL_REF) begin
      reference_divider_word <= shift_reg[21:0];
    end
  end

  // bit-rate and pin word
  always_ff @(posedge mclk) begin
    if (rst) begin
      bit_rate_and_pin_word <= `RATE_WORD_RESET;
    end else if (strobe_rise && sel_valid && sel == SEL_RATE) begin
      bit_rate_and_pin_word <= shift_reg[21:0];
    end
  end

  // crystal trim word
  always_ff @(posedge mclk) begin
    if (rst) begin
      crystal_trim_word <= `TRIM_WORD_RESET;
    end else if (strobe_rise && sel_valid && sel == SEL_TRIM) begin
      crystal_trim_word <= shift_reg[21:0];
    end
  end

  // ****************************************
  // decoded settings
  // ****************************************
  word_t active;

  // mode pin picks the shared field range 21:5
  always_ff @(posedge mclk) begin
    if (rst) begin
      active <= `MODE_ZERO_RESET;
    end else begin
      active <= mode_s ? mode_one_setting_word : mode_zero_setting_word;
    end
  end

  // standby low powers down amplifier, brownout detector and rate chain but leaves loading alive
  assign powered_up = sync_b[0];

  // settings outputs are straight from word flops; brownout enable is also gated by powered_up
  assign counter_a_ratio     = active[21:17];
  assign counter_b_ratio     = active[16:8];
  assign amp_attenuation     = active[7:6];
  assign tx_path_enable      = active[5];
  assign pump_current_select = mode_zero_setting_word[3:2];
  assign band_divider_select = mode_zero_setting_word[1:0];
  assign fsk_select          = mode_one_setting_word[4];
  assign brownout_threshold  = mode_one_setting_word[2:1];
  assign brownout_enable     = mode_one_setting_word[0] & powered_up;
  assign reference_ratio     = reference_divider_word[21:14];
  assign crystal_load_trim   = crystal_trim_word[18:16];
  assign phase_detector_reset_source = crystal_trim_word[15];

  // amplifier runs only in transmit with its gate set
  assign amp_enable = mode_one_setting_word[3] & active[5] & powered_up;

  // switch is closed only under on-off keying with the trim bit set
  assign crystal_switch_closed = crystal_trim_word[20] & ~fsk_select;

  // ****************************************
  // bit-rate divider chain
  // ****************************************
  logic [2:0] first_cnt;
  logic [6:0] second_cnt;
  logic [3:0] third_cnt;
  logic [2:0] first_max;
  logic [6:0] second_max;
  logic [3:0] third_max;
  logic       first_tick;
  logic       second_tick;
  logic       bit_rate_clock;

  // terminal counts from the rate word fields
  always_comb begin
    case (bit_rate_and_pin_word[21:20])
      2'h0:    first_max = 3'h0;
      2'h1:    first_max = 3'h4;
      2'h2:    first_max = 3'h5;
      default: first_max = 3'h7;
    endcase
    second_max = 7'((8'h01 << bit_rate_and_pin_word[19:17]) - 8'h01);
    third_max  = bit_rate_and_pin_word[16] ? 4'hE : 4'hF;
  end

  assign first_tick  = (first_cnt >= first_max);
  assign second_tick = first_tick && (second_cnt >= second_max);

  // first divider free-runs; the later stages advance only on its tick
  always_ff @(posedge mclk) begin
    if (rst || !powered_up) begin
      first_cnt <= 3'h0;
    end else begin
      first_cnt <= first_tick ? 3'h0 : first_cnt + 3'h1;
    end
  end

  // second divider; >= so a shrunk terminal count cannot strand the counter
  always_ff @(posedge mclk) begin
    if (rst || !powered_up) begin
      second_cnt <= 7'h00;
    end else if (first_tick) begin
      second_cnt <= (second_cnt >= second_max) ? 7'h00 : second_cnt + 7'h01;
    end
  end

  // third divider sets the rate clock period
  always_ff @(posedge mclk) begin
    if (rst || !powered_up) begin
      third_cnt <= 4'h0;
    end else if (second_tick) begin
      third_cnt <= (third_cnt >= third_max) ? 4'h0 : third_cnt + 4'h1;
    end
  end

  // rate clock rises at the wrap and falls about mid-count; stopped in standby
  always_ff @(posedge mclk) begin
    if (rst || !powered_up) begin
      bit_rate_clock <= 1'b0;
    end else if (second_tick) begin
      if (third_cnt >= third_max) begin
        bit_rate_clock <= 1'b1;
      end else if (third_cnt == 4'h7) begin
        bit_rate_clock <= 1'b0;
      end
    end
  end

  // ****************************************
  // transmit data capture through the fifo
  // ****************************************
  logic capture;
  logic rate_prev;
  logic rate_rise;
  logic fifo_in_ready;
  logic fifo_out_data;
  logic fifo_out_valid;
  logic captured_bit;
  logic data_sync_a;
  logic data_sync_b;

  assign capture   = bit_rate_and_pin_word[15];
  assign rate_rise = bit_rate_clock & ~rate_prev;

  // sampled data is synchronised first; raw path stays unclocked
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_sync_a <= 1'b0;
      data_sync_b <= 1'b0;
    end else begin
      data_sync_a <= tx_data;
      data_sync_b <= data_sync_a;
    end
  end

  // rate clock history for the capture edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      rate_prev <= 1'b0;
    end else begin
      rate_prev <= bit_rate_clock;
    end
  end

  // fifo drains at once; it only fills if the modulator side stalls
  bit_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (data_sync_b),
    .in_valid  (capture & rate_rise),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (powered_up)
  );

  // last captured bit holds until the next one
  always_ff @(posedge mclk) begin
    if (rst) begin
      captured_bit <= 1'b0;
    end else if (fifo_out_valid && powered_up) begin
      captured_bit <= fifo_out_data;
    end
  end

  // direct mode is asynchronous by design, so tx_data is not sampled here
  assign modulation_data = capture ? captured_bit : tx_data;

  // ****************************************
  // multipurpose pin routing
  // ****************************************
  // a full fifo would mean lost capture; it cannot fill while powered up
  always_comb begin
    case (bit_rate_and_pin_word[12:11])
      `PIN_LOCK:     multipurpose_output_pin = lock_detect;
      `PIN_BIT_RATE_CLOCK:     multipurpose_output_pin = bit_rate_clock & fifo_in_ready;
      `PIN_BROWNOUT: multipurpose_output_pin = brownout_detect;
      default:       multipurpose_output_pin = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [design/rf_tx_defines.svh]
// offsets, reset values, pin routing codes and counts for the control word bank
// assumes inclusion by the bank; the package and the bench do not include it
`ifndef RF_TX_DEFINES_SVH
`define RF_TX_DEFINES_SVH

// address codes formed from serial bits 23,22,1,0
`define REF_WORD_ADDR       4'h8
`define RATE_WORD_ADDR      4'h9
`define SHIFT_BITS          24
`define FIFO_DEPTH          16
`define FIFO_WIDTH          1

// reset values, aligned to serial bit positions
`define MODE_ZERO_RESET     22'h0070A2
`define MODE_ONE_RESET      22'h0070A0
`define REF_WORD_RESET      22'h100000
`define RATE_WORD_RESET     22'h340000
`define TRIM_WORD_RESET     22'h008000

// multipurpose pin routing codes
`define PIN_LOCK            2'h0
`define PIN_BIT_RATE_CLOCK            2'h1
`define PIN_BROWNOUT        2'h2

`endif

// [design/rf_tx_pkg.sv]
// types shared by the control word bank and the bench
// assumes rf_tx_defines.svh is compiled alongside
package rf_tx_pkg;
  typedef logic [21:0] word_t;
  typedef enum logic [4:0] {
    SEL_MODE_ZERO = 5'h01,
    SEL_MODE_ONE  = 5'h02,
    SEL_REF       = 5'h04,
    SEL_RATE      = 5'h08,
    SEL_TRIM      = 5'h10
  } word_sel_e;
endpackage

// [design/bit_fifo.sv]
// small synchronous fifo, valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // full and empty come straight from the occupancy count
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  // storage has no reset; only the pointers and count need a defined value
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointer and count bookkeeping
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// [verification/rf_tx_control_word_bank_assertions.sv]
// checker on the ports of the control word bank
// assumes bind onto the bank, one clock mclk, sync active-high rst
`timescale 1ns/1ps
`default_nettype none
module rf_tx_bank_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       latch_strobe,
  input wire logic       mode_select,
  input wire logic       standby_pin,
  input wire logic       powered_up,
  input wire logic [4:0] counter_a_ratio,
  input wire logic [8:0] counter_b_ratio,
  input wire logic [1:0] amp_attenuation,
  input wire logic       fsk_select,
  input wire logic       amp_enable,
  input wire logic       brownout_enable,
  input wire logic [7:0] reference_ratio,
  input wire logic       crystal_switch_closed,
  input wire logic [2:0] crystal_load_trim,
  input wire logic       phase_detector_reset_source
);
  // ************************************
  // cycles since the strobe was last high
  // ************************************
  logic [3:0] quiet;
  always_ff @(posedge mclk) begin
    if (rst || latch_strobe) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1; // saturates
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RESET_DEFAULTS: assert property ($fell(rst) |-> reference_ratio == 8'h40 && counter_b_ratio == 9'h070
    && amp_attenuation == 2'h2 && crystal_load_trim == 3'h0 && phase_detector_reset_source)
    else $error("defaults missing after reset");
  AST_POWER_SYNC: assert property (!$past(rst) && !$past(rst, 2) |-> powered_up == $past(standby_pin, 2))
    else $error("powered_up does not follow standby pin");
  AST_AMP_STANDBY: assert property (!standby_pin [*3] |-> !amp_enable && !powered_up)
    else $error("amplifier on while powered down");
  AST_BROWN_STANDBY: assert property (!standby_pin [*3] |-> !brownout_enable)
    else $error("brownout detector on while powered down");
  AST_MODE_QUIET: assert property ((quiet >= 4'h8 && $stable(mode_select)) [*5]
    |-> $stable(counter_a_ratio) && $stable(counter_b_ratio) && $stable(amp_attenuation))
    else $error("active word fields moved without cause");
  AST_CFG_ONLY_STROBE: assert property (($changed(reference_ratio) || $changed(crystal_load_trim)
    || $changed(phase_detector_reset_source)) |-> quiet <= 4'h7)
    else $error("config changed without a strobe");
  AST_FSK_ONLY_STROBE: assert property ($changed(fsk_select) |-> quiet <= 4'h7)
    else $error("modulation select changed without a strobe");
  AST_XTAL_FSK: assert property (fsk_select && $past(fsk_select) |-> !crystal_switch_closed)
    else $error("crystal switch closed under frequency keying");
  cover property ($rose(mode_select));
  cover property (amp_enable);
  cover property (crystal_switch_closed);
endmodule
bind rf_tx_control_word_bank rf_tx_bank_checker u_chk (.mclk, .rst, .latch_strobe, .mode_select, .standby_pin,
  .powered_up, .counter_a_ratio, .counter_b_ratio, .amp_attenuation, .fsk_select, .amp_enable, .brownout_enable,
  .reference_ratio, .crystal_switch_closed, .crystal_load_trim, .phase_detector_reset_source);
`default_nettype wire

// [verification/host_model.sv]
// host model: writes control words over the three serial pins
// assumes mclk is the bank clock; the bench calls send
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic mclk,
  output logic      serial_clock,
  output logic      serial_data,
  output logic      latch_strobe
);
  // ************************************
  // serial writer
  // ************************************
  initial begin
    serial_clock = 1'h0; // stands still low between frames
    serial_data  = 1'h1;
    latch_strobe = 1'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // msb first, four cycles a level so the pin synchronisers see each one;
  // callers keep bit 5 set in mode words, reserved bits clear; t_pin also drives the unrouted pin code 3
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      hold(4);
      serial_clock = 1'h1;
      hold(4);
      serial_clock = 1'h0;
    end
    serial_data  = ~w[0]; // released line shows the inverse
    latch_strobe = 1'h1;
    hold(4);
    latch_strobe = 1'h0;
    hold(6);
  endtask
endmodule
`default_nettype wire

// [verification/rf_tx_control_word_bank_tb.sv]
// self-checking bench for the control word bank
// assumes host_model and the checker file compile before it
`timescale 1ns/1ps
`default_nettype none
module rf_tx_control_word_bank_tb;
  import rf_tx_pkg::*;
  // ************************************
  // clock, pins and the design
  // ************************************
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
  logic       mclk = 1'h0, rst = 1'h1, mode_select = 1'h0, standby_pin = 1'h1;
  logic       tx_data = 1'h0, lock_detect = 1'h0, brownout_detect = 1'h0;
  logic       serial_clock, serial_data, latch_strobe, powered_up, tx_path_enable, fsk_select;
  logic       amp_enable, brownout_enable, mp, modulation_data, crystal_switch_closed, pds;
  logic [4:0] counter_a_ratio;
  logic [8:0] counter_b_ratio;
  logic [1:0] amp_attenuation, pump, band, thresh;
  logic [7:0] reference_ratio;
  logic [2:0] crystal_load_trim;
  int         bad_count = 0;
  int         comparisons = 0;
  int         n;
  always #50 mclk = ~mclk; // 10 MHz
  host_model u_host (.mclk, .serial_clock, .serial_data, .latch_strobe);
  rf_tx_control_word_bank u_dut (.mclk, .rst, .serial_clock, .serial_data, .latch_strobe, .mode_select,
    .standby_pin, .tx_data, .lock_detect, .brownout_detect, .powered_up, .counter_a_ratio, .counter_b_ratio,
    .amp_attenuation, .tx_path_enable, .pump_current_select(pump), .band_divider_select(band), .fsk_select,
    .amp_enable, .brownout_threshold(thresh), .brownout_enable, .reference_ratio, .multipurpose_output_pin(mp),
    .modulation_data, .crystal_switch_closed, .crystal_load_trim, .phase_detector_reset_source(pds));
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic summarize;
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // next rise of the multipurpose pin, giving up after 399 cycles
  task automatic rise(output int k);
    logic prev;
    prev = mp;
    for (k = 1; k < 400; k++) begin
      tick(1);
      if (mp === 1'h1 && prev === 1'h0) return;
      prev = mp;
    end
    bad_count++;
    summarize;
  endtask
  task automatic t_defaults;
    `CHK("wordzero", {5'h00, 9'h070, 2'h2, 1'h1, 2'h0, 2'h2}, {counter_a_ratio, counter_b_ratio, amp_attenuation, tx_path_enable, pump, band})
    `CHK("others", {1'h0, 1'h0, 2'h0, 1'h0, 8'h40, 3'h0, 1'h1, 1'h0}, {fsk_select, amp_enable, thresh, brownout_enable, reference_ratio, crystal_load_trim, pds, crystal_switch_closed})
  endtask
  task automatic t_trim;
    u_host.send({2'h3, 22'h150000}); // address 11x0
    `CHK("trim", {1'h1, 3'h5, 1'h0}, {crystal_switch_closed, crystal_load_trim, pds})
  endtask
  task automatic t_modes;
    u_host.send({2'h0, 22'h2BA564});
    u_host.send({2'h1, 22'h145B3F});
    `CHK("mode0", {5'h15, 9'h1A5, 2'h1, 2'h1, 2'h0}, {counter_a_ratio, counter_b_ratio, amp_attenuation, pump, band})
    mode_select = 1'h1;
    tick(6);
    `CHK("mode1", {5'h0A, 9'h05B, 2'h0, 2'h1, 2'h0}, {counter_a_ratio, counter_b_ratio, amp_attenuation, pump, band})
    `CHK("word1", {1'h1, 1'h1, 2'h3, 1'h1, 1'h0}, {fsk_select, amp_enable, thresh, brownout_enable, crystal_switch_closed})
    standby_pin = 1'h0;
    tick(6);
    `CHK("standby", 3'h0, {amp_enable, brownout_enable, powered_up})
    u_host.send({2'h0, 22'h2BA565}); // programming while powered down
    standby_pin = 1'h1;
    mode_select = 1'h0;
    tick(6);
    `CHK("band", {2'h1, 5'h15}, {band, counter_a_ratio})
  endtask
  task automatic t_ref;
    u_host.send({2'h2, 22'h3FC000});
    `CHK("ref", 8'hFF, reference_ratio)
    u_host.send({2'h2, 22'h004002}); // address 1010 is not decoded
    `CHK("refused", 8'hFF, reference_ratio)
    u_host.send({2'h2, 22'h008000});
    `CHK("ref2", 8'h02, reference_ratio)
  endtask
  task automatic t_pin;
    logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
    foreach (codes[i]) begin
      u_host.send(24'hB40001 | {11'h000, codes[i], 11'h000});
      lock_detect = 1'h1;
      tick(1);
      `CHK("lock", codes[i] == 2'h0, mp)
      lock_detect = 1'h0;
      brownout_detect = 1'h1;
      tick(1);
      `CHK("brown", codes[i] == 2'h2, mp)
      brownout_detect = 1'h0;
    end
    tx_data = 1'h1;
    #1 `CHK("direct", 1'h1, modulation_data)
    tick(1);
    tx_data = 1'h0;
    #1 `CHK("direct", 1'h0, modulation_data)
  endtask
  task automatic t_rate;
    u_host.send(24'h928801); // 5 x 2 x 16
    rise(n);
    rise(n);
    `CHK("period", 160, n)
    u_host.send(24'h818801); // 1 x 1 x 15, clock on the pin
    rise(n);
    rise(n);
    `CHK("period", 15, n)
    tx_data = 1'h1;
    tick(60);
    `CHK("capture", 1'h1, modulation_data)
    tx_data = 1'h0;
    tick(60);
    `CHK("capture", 1'h0, modulation_data)
  endtask
  initial begin
    tick(12);
    rst = 1'h0;
    tick(2);
    t_defaults;
    t_trim;
    t_modes;
    t_ref;
    t_pin;
    t_rate;
    summarize;
  end
endmodule
`default_nettype wire
